/* File: verilog/psc_top.sv */
// supervisor companion: reset control, watchdog, comparator, counters, serial number
`default_nettype none
module psc_top
	import psc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// supply monitor and comparator results
	input wire logic [3:0] supply_level,
	input wire logic power_fail_sense_input,
	// event pins
	input wire logic event_input_one,
	input wire logic event_input_two,
	// reset pin, open drain
	input wire logic sys_rst_n_in,
	output logic sys_rst_n_out,
	output logic sys_rst_n_oe,
	// warning and interrupt
	output logic early_fail_warning_output,
	output logic irq
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] pins_raw;
	logic [3:0] pins_sync;
	// idle-high pins inverted so the synchroniser reset value is their idle level
	assign pins_raw = {!sys_rst_n_in, !power_fail_sense_input, event_input_two, event_input_one};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			psc_sync u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin_in(pins_raw[gi]),
				.level_out(pins_sync[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] ctrl_reg;
	logic [11:0] wdt_ms_reg;
	logic [63:0] sn_reg;
	logic [15:0] cnt_reg [2];
	logic [2:0] src_reg;
	logic [IRQ_W-1:0] irq_st_reg;
	logic [IRQ_W-1:0] irq_msk_reg;
	logic [IRQ_W-1:0] irq_ev;
	logic kick;
	logic src_clr;
	logic [IRQ_W-1:0] irq_clr;

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go;
	logic wr_hit;

	function automatic logic known_addr(input logic [7:0] a);
		return a inside {OFS_CTRL, OFS_STAT, OFS_WDT, OFS_KICK, OFS_EVENT_INPUT_ONE, OFS_EVENT_INPUT_TWO,
			OFS_SN_LO, OFS_SN_HI, OFS_IRQ_ST, OFS_IRQ_MSK};
	endfunction : known_addr

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_hit = wr_go && known_addr(aw_addr_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known_addr(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign kick = wr_hit && aw_addr_reg == OFS_KICK;
	assign src_clr = wr_hit && aw_addr_reg == OFS_STAT;
	assign irq_clr = (wr_hit && aw_addr_reg == OFS_IRQ_ST) ? w_data_reg[IRQ_W-1:0] : '0;

	// control, watchdog period, mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RST;
			wdt_ms_reg <= WDT_RST_MS;
			irq_msk_reg <= '0;
		end else if (wr_hit) begin
			if (aw_addr_reg == OFS_CTRL) begin
				ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
				if (ctrl_reg[CTRL_SN_LOCK]) begin
					ctrl_reg[CTRL_SN_LOCK] <= 1'b1;
				end
			end
			if (aw_addr_reg == OFS_WDT) begin
				logic [31:0] m;
				m = merge({20'h00000, wdt_ms_reg}, w_data_reg, w_strb_reg);
				if (m < 32'(WDT_MIN_MS)) begin
					wdt_ms_reg <= 12'(WDT_MIN_MS);
				end else if (m > 32'(WDT_MAX_MS)) begin
					wdt_ms_reg <= 12'(WDT_MAX_MS);
				end else begin
					wdt_ms_reg <= m[11:0];
				end
			end
			if (aw_addr_reg == OFS_IRQ_MSK) begin
				irq_msk_reg <= w_data_reg[IRQ_W-1:0];
			end
		end
	end

	// serial number, refused once locked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sn_reg <= 64'h0000_0000_0000_0000;
		end else if (wr_hit && !ctrl_reg[CTRL_SN_LOCK]) begin
			if (aw_addr_reg == OFS_SN_LO) begin
				sn_reg[31:0] <= merge(sn_reg[31:0], w_data_reg, w_strb_reg);
			end
			if (aw_addr_reg == OFS_SN_HI) begin
				sn_reg[63:32] <= merge(sn_reg[63:32], w_data_reg, w_strb_reg);
			end
		end
	end

	// ----------------------------------------
	// manual reset debounce
	// ----------------------------------------
	logic [19:0] deb_cnt_reg;
	logic man_reg;
	logic man_prev_reg;
	logic pin_low_ext;
	// own drive excluded so the block cannot latch itself
	assign pin_low_ext = pins_sync[3] && !sys_rst_n_oe;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deb_cnt_reg <= '0;
			man_reg <= 1'b0;
			man_prev_reg <= 1'b0;
		end else begin
			man_prev_reg <= man_reg;
			if (pin_low_ext == man_reg) begin
				deb_cnt_reg <= '0;
			end else if (deb_cnt_reg == 20'(DEB_CYC - 1)) begin
				man_reg <= pin_low_ext;
				deb_cnt_reg <= '0;
			end else begin
				deb_cnt_reg <= deb_cnt_reg + 20'd1;
			end
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	logic [14:0] ms_cnt_reg;
	logic ms_tick;
	logic [11:0] wdt_cnt_reg;
	logic wdt_fire;
	logic rst_active;
	assign ms_tick = ms_cnt_reg == 15'(CYC_PER_MS - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn || ms_tick) begin
			ms_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 15'd1;
		end
	end
	assign wdt_fire = ctrl_reg[CTRL_WDT_EN] && ms_tick && !kick && !rst_active
		&& wdt_cnt_reg >= wdt_ms_reg - 12'd1;
	always_ff @(posedge aclk) begin
		if (!aresetn || kick || !ctrl_reg[CTRL_WDT_EN] || rst_active) begin
			wdt_cnt_reg <= '0;
		end else if (ms_tick) begin
			wdt_cnt_reg <= wdt_fire ? 12'd0 : wdt_cnt_reg + 12'd1;
		end
	end

	// ----------------------------------------
	// reset sequencer
	// ----------------------------------------
	psc_rst_e st_reg;
	logic [21:0] hold_cnt_reg;
	logic supply_low;
	psc_cause_s cause;
	assign supply_low = supply_level < ctrl_reg[CTRL_TRIP_LSB +: TRIP_W];
	assign cause = '{supply_low: supply_low, wdt_expire: wdt_fire,
		manual: man_reg && !man_prev_reg};
	assign rst_active = st_reg != PSC_IDLE;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= PSC_IDLE;
			hold_cnt_reg <= '0;
		end else begin
			unique case (st_reg)
				PSC_IDLE: begin
					if (cause.supply_low) begin
						st_reg <= PSC_WAIT;
					end else if (cause.wdt_expire || cause.manual) begin
						st_reg <= PSC_HOLD;
						hold_cnt_reg <= '0;
					end
				end
				PSC_WAIT: begin
					hold_cnt_reg <= '0;
					if (!supply_low) begin
						st_reg <= PSC_HOLD;
					end
				end
				PSC_HOLD: begin
					if (supply_low) begin
						st_reg <= PSC_WAIT;
					end else if (hold_cnt_reg == 22'(RST_HOLD_CYC - 1)) begin
						st_reg <= PSC_IDLE;
					end else begin
						hold_cnt_reg <= hold_cnt_reg + 22'd1;
					end
				end
			endcase
		end
	end
	// open drain: drive low only, pull-up outside
	assign sys_rst_n_out = 1'b0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_rst_n_oe <= 1'b0;
		end else begin
			sys_rst_n_oe <= st_reg != PSC_IDLE || cause.supply_low;
		end
	end

	// source flags, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_reg <= '0;
		end else if (st_reg == PSC_IDLE && (cause.supply_low || cause.wdt_expire
			|| cause.manual)) begin
			src_reg <= {cause.manual, cause.wdt_expire, cause.supply_low};
		end else if (src_clr) begin
			src_reg <= src_reg & ~w_data_reg[2:0];
		end
	end

	// ----------------------------------------
	// comparator warning and event counters
	// ----------------------------------------
	logic [1:0] ev_prev_reg;
	logic [1:0] ev_hit;
	logic pfw_prev_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			early_fail_warning_output <= 1'b0;
			pfw_prev_reg <= 1'b0;
		end else begin
			early_fail_warning_output <= pins_sync[2];
			pfw_prev_reg <= early_fail_warning_output;
		end
	end
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cnt
			logic pol;
			assign pol = ctrl_reg[CTRL_POL1 + gi];
			// pol 1: falling edge, pol 0: rising edge
			assign ev_hit[gi] = pol ? (ev_prev_reg[gi] && !pins_sync[gi])
				: (!ev_prev_reg[gi] && pins_sync[gi]);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ev_prev_reg[gi] <= 1'b0;
					cnt_reg[gi] <= '0;
				end else begin
					ev_prev_reg[gi] <= pins_sync[gi];
					if (wr_hit && aw_addr_reg == (gi == 0 ? OFS_EVENT_INPUT_ONE : OFS_EVENT_INPUT_TWO)) begin
						cnt_reg[gi] <= w_data_reg[15:0];
					end else if (ev_hit[gi]) begin
						cnt_reg[gi] <= cnt_reg[gi] + 16'd1;
					end
				end
			end
		end
	endgenerate
	// counters sit in this block's always-on domain

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign irq_ev = {|ev_hit, early_fail_warning_output && !pfw_prev_reg,
		cause.manual, cause.wdt_expire, cause.supply_low && st_reg == PSC_IDLE};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_reg <= '0;
			irq <= 1'b0;
		end else begin
			irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
			irq <= |(irq_st_reg & irq_msk_reg);
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (s_axi_araddr[7:2])
			OFS_CTRL[7:2]: rd_mux = ctrl_reg;
			OFS_STAT[7:2]: begin
				rd_mux[2:0] = src_reg;
				rd_mux[STAT_PFW] = early_fail_warning_output;
				rd_mux[STAT_RST_ACT] = rst_active;
			end
			OFS_WDT[7:2]: rd_mux[11:0] = wdt_ms_reg;
			OFS_EVENT_INPUT_ONE[7:2]: rd_mux[15:0] = cnt_reg[0];
			OFS_EVENT_INPUT_TWO[7:2]: rd_mux[15:0] = cnt_reg[1];
			OFS_SN_LO[7:2]: rd_mux = sn_reg[31:0];
			OFS_SN_HI[7:2]: rd_mux = sn_reg[63:32];
			OFS_IRQ_ST[7:2]: rd_mux[IRQ_W-1:0] = irq_st_reg;
			OFS_IRQ_MSK[7:2]: rd_mux[IRQ_W-1:0] = irq_msk_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= known_addr({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : psc_top
`default_nettype wire

/* File: verilog/psc_pkg.sv */
// package: constants and carriers for the processor supervisor companion
`default_nettype none
package psc_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int RST_HOLD_MS = 100;
	localparam int WDT_MIN_MS = 100;
	localparam int WDT_MAX_MS = 3000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * CYC_PER_MS;
	localparam int DEB_MS = 10;
	localparam int DEB_CYC = DEB_MS * CYC_PER_MS;
	localparam logic [11:0] WDT_RST_MS = 12'd1000;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_WDT = 8'h08;
	localparam logic [7:0] OFS_KICK = 8'h0c;
	localparam logic [7:0] OFS_EVENT_INPUT_ONE = 8'h10;
	localparam logic [7:0] OFS_EVENT_INPUT_TWO = 8'h14;
	localparam logic [7:0] OFS_SN_LO = 8'h18;
	localparam logic [7:0] OFS_SN_HI = 8'h1c;
	localparam logic [7:0] OFS_IRQ_ST = 8'h20;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h24;
	// ----------------------------------------
	// control fields and reset values
	// ----------------------------------------
	localparam int CTRL_WDT_EN = 0;
	localparam int CTRL_POL1 = 1;
	localparam int CTRL_POL2 = 2;
	localparam int CTRL_SN_LOCK = 3;
	localparam int CTRL_TRIP_LSB = 8;
	localparam int TRIP_W = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int STAT_SRC_LVD = 0;
	localparam int STAT_SRC_WDT = 1;
	localparam int STAT_SRC_MAN = 2;
	localparam int STAT_PFW = 4;
	localparam int STAT_RST_ACT = 5;
	localparam int IRQ_W = 5;
	localparam int IRQ_LVD = 0;
	localparam int IRQ_WDT = 1;
	localparam int IRQ_MAN = 2;
	localparam int IRQ_PFW = 3;
	localparam int IRQ_CNT = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic supply_low;
		logic wdt_expire;
		logic manual;
	} psc_cause_s;
	typedef enum logic [1:0] {
		PSC_IDLE,
		PSC_HOLD,
		PSC_WAIT
	} psc_rst_e;
endpackage : psc_pkg
`default_nettype wire

/* File: verilog/psc_sync.sv */
// three-stage pin synchroniser with agreement on the last two stages
`default_nettype none
module psc_sync
	import psc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pin and result
	input wire logic pin_in,
	output logic level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_out <= s3_reg;
			end
		end
	end
endmodule : psc_sync
`default_nettype wire

/* File: verification/psc_top_assertions.sv */
// checker: port assertions for the supervisor companion
`default_nettype none
module psc_top_checker
	import psc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// supervisor pins
	input wire logic power_fail_sense_input,
	input wire logic sys_rst_n_out,
	input wire logic sys_rst_n_oe,
	input wire logic early_fail_warning_output
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// bus
	// ----------------------------------------
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response dropped");
	a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// ----------------------------------------
	// supervisor
	// ----------------------------------------
	a_open_drain: assert property (sys_rst_n_out == 1'b0)
		else $error("reset pin driven high");
	a_rst_min_hold: assert property ($rose(sys_rst_n_oe) |=> sys_rst_n_oe [*8])
		else $error("reset pulse too short");
	a_warn_on: assert property (!power_fail_sense_input [*7] |-> early_fail_warning_output)
		else $error("warning missing");
	a_warn_off: assert property (power_fail_sense_input [*7] |-> !early_fail_warning_output)
		else $error("warning stuck");
endmodule : psc_top_checker
`default_nettype wire

/* File: verification/psc_host_model.sv */
// host side model: reset wire with pull-up and push button
`default_nettype none
module psc_host_model
	import psc_pkg::*;
(
	// reset wire parties
	input wire logic rst_out,
	input wire logic rst_oe,
	input wire logic button_low,
	// resolved wire and host view
	output logic pin_level,
	output var int resets_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	// weak pull-up unless some party pulls low
	assign pin_level = ((rst_oe && !rst_out) || button_low) ? 1'b0 : 1'b1;
	initial resets_seen = 0;
	// host counts entries into reset
	always @(negedge pin_level) begin
		resets_seen++;
	end
endmodule : psc_host_model
`default_nettype wire

/* File: verification/psc_tb_top.sv */
// testbench: bus driven tests for the supervisor companion
`default_nettype none
module psc_tb_top
	import psc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, button_low, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0] s_axi_wstrb, supply_level;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic power_fail_sense_input, event_input_one, event_input_two;
	logic sys_rst_n_in, sys_rst_n_out, sys_rst_n_oe, early_fail_warning_output;
	int n_errors, tests_run, resets_seen;
	psc_top u_psc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_level, .power_fail_sense_input,
		.event_input_one, .event_input_two, .sys_rst_n_in, .sys_rst_n_out, .sys_rst_n_oe,
		.early_fail_warning_output, .irq);
	psc_host_model u_psc_host_model (.rst_out(sys_rst_n_out), .rst_oe(sys_rst_n_oe),
		.button_low, .pin_level(sys_rst_n_in), .resets_seen);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		int n;
		b_t = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_t && n < 50) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			last_resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
			if (b_t)
				s_axi_bready <= 1'b0;
			n++;
		end
		chk({31'h0, b_t}, 32'h1);
		@(posedge aclk);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic ar_t, r_t;
		int n;
		r_t = 1'b0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_t && n < 50) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			rd_data = s_axi_rdata;
			last_resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
			if (r_t)
				s_axi_rready <= 1'b0;
			n++;
		end
		chk(rd_data, exp);
		@(posedge aclk);
	endtask : rc
	task automatic tog(input int i, input int n);
		repeat (n) begin
			if (i == 0)
				event_input_one <= ~event_input_one;
			else
				event_input_two <= ~event_input_two;
			repeat (8) @(posedge aclk);
		end
	endtask : tog
	task automatic stop_test;
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic [7:0] ca;
		n_errors = 0;
		tests_run = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		supply_level = 4'h8;
		power_fail_sense_input = 1'b1;
		{event_input_one, event_input_two, button_low} = 3'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		rc(OFS_CTRL, CTRL_RST);
		rc(OFS_WDT, 32'h0000_03e8);
		wr(OFS_WDT, 32'h0000_0032);
		rc(OFS_WDT, 32'h0000_0064);
		wr(OFS_WDT, 32'h0000_1388);
		rc(OFS_WDT, 32'h0000_0bb8);
		rc(8'h40, 32'h0);
		chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'h1);
		chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
		wr(OFS_CTRL, 32'h1);
		wr(OFS_KICK, 32'h1);
		chk({31'h0, sys_rst_n_oe}, 32'h0);
		wr(OFS_SN_LO, 32'h1234_5678);
		wr(OFS_SN_HI, 32'h9abc_def0);
		wr(OFS_CTRL, 32'h8);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_SN_LO, 32'h0);
		chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
		rc(OFS_SN_LO, 32'h1234_5678);
		rc(OFS_SN_HI, 32'h9abc_def0);
		rc(OFS_CTRL, 32'h8);
		for (int i = 0; i < 2; i++) begin
			ca = OFS_EVENT_INPUT_ONE + 8'(4 * i);
			tog(i, 3);
			rc(ca, 32'h2);
			wr(OFS_CTRL, 32'h8 | (32'h2 << i));
			tog(i, 2);
			rc(ca, 32'h3);
			wr(OFS_CTRL, 32'h8);
			wr(ca, 32'hffff);
			tog(i, 2);
			rc(ca, 32'h0);
		end
		rc(OFS_IRQ_ST, 32'h10);
		power_fail_sense_input <= 1'b0;
		repeat (8) @(posedge aclk);
		chk({31'h0, early_fail_warning_output}, 32'h1);
		rc(OFS_STAT, 32'h10);
		rc(OFS_IRQ_ST, 32'h18);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MSK, 32'h8);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_ST, 32'h8);
		chk({31'h0, irq}, 32'h0);
		power_fail_sense_input <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({31'h0, early_fail_warning_output}, 32'h0);
		wr(OFS_IRQ_MSK, 32'h10);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_ST, 32'h10);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_CTRL, 32'h0808);
		supply_level <= 4'h3;
		repeat (3) @(posedge aclk);
		chk({31'h0, sys_rst_n_oe}, 32'h1);
		chk({31'h0, sys_rst_n_in}, 32'h0);
		rc(OFS_STAT, 32'h21);
		supply_level <= 4'h9;
		repeat (1000) @(posedge aclk);
		chk({31'h0, sys_rst_n_oe}, 32'h1);
		rc(OFS_STAT, 32'h21);
		wr(OFS_STAT, 32'h1);
		rc(OFS_STAT, 32'h20);
		chk(32'(resets_seen), 32'h1);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		chk({31'h0, sys_rst_n_oe}, 32'h0);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		stop_test();
	end
endmodule : psc_tb_top
bind psc_top psc_top_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .power_fail_sense_input,
	.sys_rst_n_out, .sys_rst_n_oe, .early_fail_warning_output);
`default_nettype wire
